// ===== lin_mode_pkg.sv
package lin_mode_pkg;

    localparam int CLOCK_MHZ           = 100;
    // nominal times in microseconds; real values are set per design
    localparam int MSEL_MIN_US         = 5;
    localparam int MSEL_MAX_US         = 15;
    localparam int WAKE_DOM_MIN_US     = 30;
    localparam int TX_DOM_TIMEOUT_US   = 2000;
    localparam int MSEL_MIN_CYCLES     = MSEL_MIN_US * CLOCK_MHZ;
    localparam int MSEL_MAX_CYCLES     = MSEL_MAX_US * CLOCK_MHZ;
    localparam int WAKE_DOM_MIN_CYCLES = WAKE_DOM_MIN_US * CLOCK_MHZ;
    localparam int TX_DOM_CYCLES       = TX_DOM_TIMEOUT_US * CLOCK_MHZ;
    localparam int TIMER_W             = 24;
    localparam int FIFO_DEPTH          = 32;
    localparam int FIFO_WIDTH          = 1;

    typedef enum logic [4:0] {
        MODE_POWERON = 5'h01,
        MODE_STANDBY = 5'h02,
        MODE_NORMAL  = 5'h04,
        MODE_SELECT  = 5'h08,
        MODE_SLEEP   = 5'h10
    } mode_e;

    typedef struct packed {
        logic supplyOk;
        logic overTemp;
        logic vccOk;
    } power_s;

    typedef struct packed {
        logic regulatorOn;
        logic transceiverOn;
        logic regulatorGood;
    } power_out_s;

endpackage : lin_mode_pkg

// ===== bit_fifo.sv
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady,
    input  wire logic             flush
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
    } fifo_s;

    fifo_s state_q;
    fifo_s state_d;
    logic  doWrite;
    logic  doRead;

    assign inReady  = (state_q.count != (AW+1)'(DEPTH));
    assign outValid = (state_q.count != '0);
    assign outData  = state_q.mem[state_q.rdPtr];
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;

    always_comb begin
        state_d = state_q;
        if (flush) begin
            state_d.wrPtr = '0;
            state_d.rdPtr = '0;
            state_d.count = '0;
        end else begin
            if (doWrite) begin
                state_d.mem[state_q.wrPtr] = inData;
                state_d.wrPtr = (state_q.wrPtr == AW'(DEPTH-1)) ? '0 : state_q.wrPtr + 1'b1;
            end
            if (doRead) begin
                state_d.rdPtr = (state_q.rdPtr == AW'(DEPTH-1)) ? '0 : state_q.rdPtr + 1'b1;
            end
            if (doWrite && !doRead) begin
                state_d.count = state_q.count + 1'b1;
            end else if (doRead && !doWrite) begin
                state_d.count = state_q.count - 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : bit_fifo

// ===== lin_transceiver_mode_control.sv
// Functional notes
// - low supply or overtemperature holds power-on mode, regulator off, good output low.
// - supply above threshold without overtemperature moves power-on to standby automatically.
// - standby keeps regulator on, transceiver off, wake armed, low receive flags wake.
// - selection window with enable low, transmit high, good high gives standby.
// - valid remote wake in sleep moves to standby.
// - enable rising in standby with good high moves to normal.
// - enable rising in sleep moves directly to normal.
// - normal mode drives bus from transmit and shows bus level on receive.
// - sleep turns regulator and transceiver off, good low, wake detection active.
// - sleep entered only from normal window with enable low, transmit low.
// - enable falling blocks transmit at once and opens the window; transmit is sampled after minimum time.
// - standby or sleep decision completes within the maximum mode-select time.
// - good output low whenever regulator output is under voltage.
// - wake needs bus falling then rising edge with low time above minimum.
// - after valid wake the receive output is driven low as a flag.
// - transmit falling edge starts timeout; overlong low disables transmitter.
// - transmit rising edge clears the dominant timeout timer.
// - overtemperature in normal or standby forces power-on; recovery goes to standby.
// - floating transmit input reads high, keeping the bus recessive.
// - bus driver off whenever enable or regulator-good output is low.
// - after entering normal, driver enabled only after transmit seen high.
module lin_transceiver_mode_control
    import lin_mode_pkg::*;
#(
    parameter int MSEL_MIN  = MSEL_MIN_CYCLES,
    parameter int MSEL_MAX  = MSEL_MAX_CYCLES,
    parameter int WAKE_MIN  = WAKE_DOM_MIN_CYCLES,
    parameter int TX_DOM    = TX_DOM_CYCLES,
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic txIn,
    input  wire logic txFloating,
    input  wire logic enable,
    input  wire logic supplyOk,
    input  wire logic overTemp,
    input  wire logic vccOk,
    input  wire logic busIn,
    output logic      busDriveDominant,
    output logic      rxOut,
    output logic      regulator_good_out,
    output logic      regulatorOn,
    output logic      transceiverOn,
    output logic      wakeFlag,
    output logic      txTimedOut,
    output logic      rxOverflow,
    output mode_e     modeOut
);
    typedef struct packed {
        mode_e             mode;
        logic [TIMER_W-1:0] selTimer;
        logic [TIMER_W-1:0] wakeTimer;
        logic [TIMER_W-1:0] domTimer;
        logic              txPrev;
        logic              busPrev;
        logic              enPrev;
        logic              wakeLow;
        logic              wake;
        logic              timedOut;
        logic              txSeenHigh;
        logic              sampledTx;
        logic              drive;
        logic              rx;
        logic              good;
        logic              regOn;
        logic              xcvrOn;
        logic              overflow;
    } ctrl_s;

    ctrl_s      state_q;
    ctrl_s      state_d;
    logic       txEff;
    logic       wakeValid;
    logic       fifoInReady;
    logic       fifoOutValid;
    logic [0:0] fifoOutData;
    logic       fifoFlush;
    logic       fifoPush;

    assign txEff = txIn | txFloating;

    // wake qualifier: bus rising edge after a low run longer than the minimum
    assign wakeValid = state_q.wakeLow && busIn && !state_q.busPrev
                       && (state_q.wakeTimer > TIMER_W'(WAKE_MIN));

    // received bus bits are buffered on their way to the receive output
    assign fifoFlush = (state_q.mode != MODE_NORMAL);
    assign fifoPush  = (state_q.mode == MODE_NORMAL);

    bit_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (BUF_DEPTH)
    ) u_rx_fifo (
        .clock    (clock),
        .reset    (reset),
        .inData   (busIn),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (1'b1),
        .flush    (fifoFlush)
    );

    always_comb begin
        state_d         = state_q;
        state_d.txPrev  = txEff;
        state_d.busPrev = busIn;
        state_d.enPrev  = enable;

        // remote wake detection, armed in standby and sleep modes only
        if (state_q.mode == MODE_STANDBY || state_q.mode == MODE_SLEEP) begin
            if (!busIn && state_q.busPrev) begin
                state_d.wakeLow   = 1'b1;
                state_d.wakeTimer = '0;
            end else if (!busIn && state_q.wakeLow) begin
                if (state_q.wakeTimer != '1) begin
                    state_d.wakeTimer = state_q.wakeTimer + 1'b1;
                end
            end else if (busIn) begin
                state_d.wakeLow = 1'b0;
            end
            if (wakeValid) begin
                state_d.wake = 1'b1;
            end
        end else begin
            state_d.wakeLow   = 1'b0;
            state_d.wakeTimer = '0;
        end

        // dominant timeout on the transmit input
        if (!txEff && state_q.txPrev) begin
            state_d.domTimer = '0;
            state_d.timedOut = 1'b0;
        end else if (txEff && !state_q.txPrev) begin
            state_d.domTimer = '0;
            state_d.timedOut = 1'b0;
        end else if (!txEff && !state_q.timedOut) begin
            state_d.domTimer = state_q.domTimer + 1'b1;
            if (state_q.domTimer >= TIMER_W'(TX_DOM - 1)) begin
                state_d.timedOut = 1'b1;
            end
        end

        case (state_q.mode)
            MODE_POWERON: begin
                if (supplyOk && !overTemp) begin
                    state_d.mode = MODE_STANDBY;
                end
            end
            MODE_STANDBY: begin
                if (enable && !state_q.enPrev && state_q.good) begin
                    state_d.mode       = MODE_NORMAL;
                    state_d.txSeenHigh = 1'b0;
                    // a wake landing on the same edge as the clear still wins
                    state_d.wake       = wakeValid;
                end
            end
            MODE_NORMAL: begin
                if (txEff) begin
                    state_d.txSeenHigh = 1'b1;
                end
                if (!enable && state_q.enPrev) begin
                    state_d.mode     = MODE_SELECT;
                    state_d.selTimer = '0;
                end
            end
            MODE_SELECT: begin
                state_d.selTimer = state_q.selTimer + 1'b1;
                if (state_q.selTimer == TIMER_W'(MSEL_MIN)) begin
                    state_d.sampledTx = txEff;
                end
                if (state_q.selTimer >= TIMER_W'(MSEL_MAX - 1)) begin
                    if (enable || !state_q.good) begin
                        state_d.mode = enable ? MODE_NORMAL : MODE_STANDBY;
                    end else if (state_q.sampledTx) begin
                        state_d.mode = MODE_STANDBY;
                    end else begin
                        state_d.mode = MODE_SLEEP;
                    end
                    state_d.txSeenHigh = 1'b0;
                end
            end
            MODE_SLEEP: begin
                if (enable && !state_q.enPrev) begin
                    state_d.mode       = MODE_NORMAL;
                    state_d.txSeenHigh = 1'b0;
                    state_d.wake       = wakeValid;
                end else if (wakeValid) begin
                    state_d.mode = MODE_STANDBY;
                end
            end
            default: begin
                state_d.mode = MODE_POWERON;
            end
        endcase

        if (!supplyOk || overTemp) begin
            state_d.mode = MODE_POWERON;
        end

        state_d.regOn  = (state_d.mode == MODE_STANDBY) || (state_d.mode == MODE_NORMAL)
                         || (state_d.mode == MODE_SELECT);
        state_d.xcvrOn = (state_d.mode == MODE_NORMAL) || (state_d.mode == MODE_SELECT);
        state_d.good   = state_d.regOn && vccOk;

        // driver gating: enable, regulator good, tx seen high, no timeout
        state_d.drive = (state_d.mode == MODE_NORMAL) && enable && state_d.good
                        && state_d.txSeenHigh && !state_d.timedOut
                        && !txEff;

        if (state_d.mode == MODE_NORMAL) begin
            state_d.rx = fifoOutValid ? fifoOutData[0] : busIn;
        end else if (state_d.mode == MODE_SELECT) begin
            state_d.rx = 1'b1;
        end else begin
            state_d.rx = !state_d.wake;
        end

        if (fifoPush && !fifoInReady) begin
            state_d.overflow = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q        <= '0;
            state_q.mode   <= MODE_POWERON;
            state_q.txPrev <= 1'b1;
            state_q.busPrev <= 1'b1;
            state_q.rx     <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign busDriveDominant   = state_q.drive;
    assign rxOut              = state_q.rx;
    assign regulator_good_out = state_q.good;
    assign regulatorOn        = state_q.regOn;
    assign transceiverOn      = state_q.xcvrOn;
    assign wakeFlag           = state_q.wake;
    assign txTimedOut         = state_q.timedOut;
    assign rxOverflow         = state_q.overflow;
    assign modeOut            = state_q.mode;

endmodule : lin_transceiver_mode_control

// ===== lin_transceiver_mode_control_checker.sv
module lin_transceiver_mode_control_checker
    import lin_mode_pkg::*;
#(
    parameter int MSEL_MIN = 4,
    parameter int MSEL_MAX = 12
) (
    input wire logic  clock,
    input wire logic  reset,
    input wire logic  txIn,
    input wire logic  enable,
    input wire logic  supplyOk,
    input wire logic  overTemp,
    input wire logic  vccOk,
    input wire logic  busDriveDominant,
    input wire logic  rxOut,
    input wire logic  regulator_good_out,
    input wire logic  regulatorOn,
    input wire logic  transceiverOn,
    input wire logic  wakeFlag,
    input wire logic  txTimedOut,
    input mode_e      modeOut
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    poweron_hold_a: assert property ((!supplyOk || overTemp) |=> modeOut == MODE_POWERON && !regulator_good_out)
        else $error("power-on not held");
    good_low_a: assert property (!vccOk |=> !regulator_good_out)
        else $error("good output high under voltage");
    drive_gate_a: assert property (!enable |=> !busDriveDominant)
        else $error("driver on with enable low");
    sleep_entry_a: assert property ($changed(modeOut) && modeOut == MODE_SLEEP |-> $past(modeOut) == MODE_SELECT)
        else $error("sleep entered from wrong mode");
    select_min_a: assert property ($rose(modeOut == MODE_SELECT) |-> (modeOut == MODE_SELECT)[*4])
        else $error("window left too early");
    select_max_a: assert property ($rose(modeOut == MODE_SELECT) |-> ##[1:MSEL_MAX] modeOut != MODE_SELECT)
        else $error("window too long");
    normal_entry_a: assert property (modeOut == MODE_STANDBY && $rose(enable) && regulator_good_out
        && supplyOk && !overTemp |=> modeOut == MODE_NORMAL)
        else $error("standby did not go normal");
    wake_rx_a: assert property ($rose(wakeFlag) |-> !rxOut)
        else $error("wake not flagged on receive");
    timeout_off_a: assert property (txTimedOut |-> !busDriveDominant)
        else $error("driver on after timeout");
    sleep_power_a: assert property (modeOut == MODE_SLEEP && $past(modeOut) == MODE_SLEEP
        |-> !regulator_good_out && !regulatorOn && !transceiverOn)
        else $error("sleep outputs wrong");
    standby_power_a: assert property (modeOut == MODE_STANDBY && $past(modeOut) == MODE_STANDBY
        |-> regulatorOn && !transceiverOn)
        else $error("standby outputs wrong");
endmodule : lin_transceiver_mode_control_checker

bind lin_transceiver_mode_control lin_transceiver_mode_control_checker #(
    .MSEL_MIN(MSEL_MIN),
    .MSEL_MAX(MSEL_MAX)
) chk (.*);

// ===== lin_ctrl_model.sv
module lin_ctrl_model (
    input  wire logic clock,
    input  wire logic enReq,
    input  wire logic txReq,
    input  wire logic rude,
    output logic      enable,
    output logic      txIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic enS;
    logic txS;
    logic rudeS;
    initial begin
        enable = 1'b0;
        txIn   = 1'b1;
    end
    // tx held at requested level through the window; released high on enable rise unless rude is set
    // requests are taken on the edge, so the bench's own drive time never races them
    always @(posedge clock) begin
        enS   = enReq;
        txS   = txReq;
        rudeS = rude;
        #1;
        txIn   = (enS && !enable && !rudeS) ? 1'b1 : txS;
        enable = enS;
    end
endmodule : lin_ctrl_model

// ===== lin_transceiver_mode_control_tb.sv
module lin_transceiver_mode_control_tb;
    import lin_mode_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic  clock = 0, reset = 1, txFloating = 0, supplyOk = 0, overTemp = 0, vccOk = 1;
    logic  enReq = 0, txReq = 1, rude = 0, busExt = 1, enable, txIn;
    logic  busDriveDominant, rxOut, regulator_good_out, regulatorOn, transceiverOn;
    logic  wakeFlag, txTimedOut, rxOverflow;
    mode_e modeOut;
    int    err_total = 0, n_checks = 0;
    bit    txQ[$];
    wire   busIn = busExt & !busDriveDominant;

    initial forever #5 clock = ~clock;

    lin_ctrl_model partner (.clock(clock), .enReq(enReq), .txReq(txReq), .rude(rude),
        .enable(enable), .txIn(txIn));

    lin_transceiver_mode_control #(.MSEL_MIN(4), .MSEL_MAX(12), .WAKE_MIN(6), .TX_DOM(20)) DUT (
        .clock(clock), .reset(reset), .txIn(txIn), .txFloating(txFloating), .enable(enable),
        .supplyOk(supplyOk), .overTemp(overTemp), .vccOk(vccOk), .busIn(busIn),
        .busDriveDominant(busDriveDominant), .rxOut(rxOut), .regulator_good_out(regulator_good_out),
        .regulatorOn(regulatorOn), .transceiverOn(transceiverOn), .wakeFlag(wakeFlag),
        .txTimedOut(txTimedOut), .rxOverflow(rxOverflow), .modeOut(modeOut));

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic to_low_power(input bit tx, input mode_e exp);
        txReq = tx;
        cyc(1);
        enReq = 0;
        cyc(3);
        chk(modeOut, MODE_SELECT);
        chk(busDriveDominant, 0);
        cyc(14);
        chk(modeOut, exp);
    endtask : to_low_power

    initial begin
        #50000;
        err_total++;
        end_of_test();
    end

    initial begin
        bit b;
        bit e;
        int run;
        run = 0;
        void'($urandom(32'hB6C3A0E3));
        cyc(2);
        reset = 0;
        cyc(3);
        chk(modeOut, MODE_POWERON);
        chk(regulator_good_out, 0);
        supplyOk = 1;
        cyc(3);
        chk(modeOut, MODE_STANDBY);
        chk({regulatorOn, transceiverOn, regulator_good_out}, 5'h05);
        rude = 1; txReq = 0; enReq = 1;
        cyc(4);
        chk(modeOut, MODE_NORMAL);
        chk(busDriveDominant, 0);
        rude = 0; txReq = 1;
        cyc(2);
        txReq = 0;
        cyc(2);
        chk(busDriveDominant, 1);
        txFloating = 1;
        cyc(2);
        chk(busDriveDominant, 0);
        txFloating = 0;
        cyc(25);
        chk({txTimedOut, busDriveDominant}, 5'h02);
        txReq = 1;
        cyc(2);
        chk(txTimedOut, 0);
        txReq = 0; cyc(15); txReq = 1; cyc(1); txReq = 0; cyc(15);
        chk({txTimedOut, busDriveDominant}, 5'h01);
        txReq = 1; cyc(2);
        txQ.push_back(1'b1);
        for (int i = 0; i < 16; i++) begin
            // low runs are capped below the dominant timeout
            b = 1'($urandom()) | (run >= 4);
            run = b ? 0 : run + 1;
            e = 1'($urandom());
            txQ.push_back(b);
            txReq = b; busExt = e;
            cyc(3);
            chk(busDriveDominant, !txQ[i+1]);
            // the bus is sampled while the previous bit still drives it
            chk(rxOut, txQ[i] & e);
        end
        busExt = 1;
        to_low_power(1, MODE_STANDBY);
        enReq = 1; cyc(3);
        to_low_power(0, MODE_SLEEP);
        chk({regulator_good_out, regulatorOn}, 0);
        busExt = 0; cyc(3); busExt = 1; cyc(2);
        chk(modeOut, MODE_SLEEP);
        chk(wakeFlag, 0);
        busExt = 0; cyc(10); busExt = 1; cyc(2);
        chk(modeOut, MODE_STANDBY);
        chk({wakeFlag, rxOut}, 5'h02);
        txReq = 1; enReq = 1; cyc(3);
        chk(wakeFlag, 0);
        to_low_power(0, MODE_SLEEP);
        txReq = 1; enReq = 1; cyc(3);
        chk(modeOut, MODE_NORMAL);
        overTemp = 1; cyc(2);
        chk(modeOut, MODE_POWERON);
        chk({regulatorOn, regulator_good_out}, 0);
        overTemp = 0; cyc(3);
        chk(modeOut, MODE_STANDBY);
        vccOk = 0; cyc(2);
        chk(regulator_good_out, 0);
        vccOk = 1;
        reset = 1; cyc(1);
        chk(modeOut, MODE_POWERON);
        chk(rxOut, 1);
        reset = 0; cyc(3);
        chk(modeOut, MODE_STANDBY);
        chk(rxOverflow, 0);
        end_of_test();
    end
endmodule : lin_transceiver_mode_control_tb
